// >>> qd_chan.sv
// qd_chan: one converter channel, input code, converter latch and zero trim
// assumes write strobes are single-cycle pulses from the serial front end
`timescale 1ns/1ps
`default_nettype none

module qd_chan
  import qd_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // writes from the front end
  input  wire logic        wr_code,
  input  wire logic        wr_zero,
  input  wire logic [15:0] wdata,
  // latch transfer and output range
  input  wire logic        ldac_n,
  input  wire logic        range_bipolar,
  // stored values
  output logic      [15:0] in_code,
  output logic      [15:0] latch_code,
  output logic      [15:0] core_code,
  output logic      [8:0]  zero_cal
);

  qd_chan_t st_q;
  qd_chan_t st_d;

  always_comb begin
    st_d = st_q;
    if (wr_code) begin
      st_d.in_code = wdata;
    end
    if (wr_zero) begin
      st_d.zero = wdata[ZERO_W-1:0];
    end
    // latch follows the input register only while the load line is low
    if (!ldac_n) begin
      st_d.latch = st_q.in_code;
    end
    // core sees straight binary: bipolar codes get their sign bit flipped
    st_d.core = range_bipolar ? (st_d.latch ^ SIGN_FLIP) : st_d.latch;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign in_code    = st_q.in_code;
  assign latch_code = st_q.latch;
  assign core_code  = st_q.core;
  assign zero_cal   = st_q.zero;

  AST_LATCH_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    ldac_n |=> st_q.latch == $past(st_q.latch))
    else $error("latch changed without a load");

  AST_CORE_CODE: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> st_q.core == ($past(range_bipolar) ? (st_q.latch ^ SIGN_FLIP)
                                                         : st_q.latch))
    else $error("core code does not follow latch and range");

endmodule

`default_nettype wire

// >>> qd_host.sv
// qd_host: serial host model that frames reads and writes into the block
// assumes mclk is free running and xfer is called from one process only
`timescale 1ns/1ps
`default_nettype none

module qd_host (
  // clock
  input  wire logic mclk,
  // serial port
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo_o,
  input  wire logic sdo_oe_n
);
  logic last_sdo = 1'b0;
  logic drove    = 1'b0;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // each sclk level lasts 3 mclk so a shifted bit settles before it is sampled
  // nb below 24 gives a cut frame that the block must drop
  task automatic xfer(input logic [23:0] w, input int nb, output logic [23:0] r);
    drove = 1'b0;
    r     = '0;
    @(posedge mclk) cs_n <= 1'b0;
    for (int i = 23; i > 23 - nb; i--) begin
      @(posedge mclk);
      sclk <= 1'b0;
      sdi  <= w[i];
      repeat (3) @(posedge mclk);
      sclk <= 1'b1;
      // a released pin shows the inverse of what it last carried
      if (!sdo_oe_n) begin
        last_sdo = sdo_o;
        drove    = 1'b1;
      end
      r[i] = sdo_oe_n ? ~last_sdo : sdo_o;
      repeat (2) @(posedge mclk);
    end
    @(posedge mclk) sclk <= 1'b0;
    repeat (3) @(posedge mclk);
    cs_n <= 1'b1;
    // released data line shows the inverse of its last value
    sdi  <= ~sdi;
    repeat (3) @(posedge mclk);
  endtask
endmodule

`default_nettype wire

// >>> qd_pkg.sv
// qd_pkg: constants and state types for the quad converter register block
// assumes every user of it imports the whole package
package qd_pkg;

  // serial frame: read flag, three spare bits, address, data word
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned RW_BIT     = 23;
  localparam int unsigned ADDR_HI    = 19;
  localparam int unsigned ADDR_LO    = 16;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned ZERO_W     = 9;

  // register addresses inside the 4-bit address field
  localparam logic [3:0] ADDR_CMD   = 4'h0;
  localparam logic [3:0] ADDR_MON   = 4'h1;
  localparam logic [3:0] ADDR_CODE0 = 4'h4;
  localparam logic [3:0] ADDR_ZERO0 = 4'h8;

  // command register fields
  localparam int unsigned RB_SEL_BIT  = 15;
  localparam int unsigned SDO_DIS_BIT = 7;
  localparam int unsigned NOP_BIT     = 6;
  localparam int unsigned GAIN_HI     = 5;
  localparam int unsigned GAIN_LO     = 2;
  localparam int unsigned RSVD_HI     = 1;

  // monitor register fields: bit 11 auxiliary input, 12..15 channels 0..3
  localparam int unsigned MON_HI = 15;
  localparam int unsigned MON_LO = 11;

  // reset values
  localparam logic [3:0]  GAIN_RST = 4'hF;
  localparam logic [4:0]  MON_RST  = 5'h00;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [8:0]  ZERO_RST = 9'h000;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;

  // per-channel storage
  typedef struct packed {
    logic [15:0] in_code;
    logic [15:0] latch;
    logic [15:0] core;
    logic [8:0]  zero;
  } qd_chan_t;

  // serial front end and control register state
  typedef struct packed {
    logic        sclk_p;
    logic        cs_p;
    logic [4:0]  cnt;
    logic [23:0] in_sh;
    logic [23:0] out_sh;
    logic        rb_sel;
    logic        serial_out_disable;
    logic [3:0]  gain;
    logic [4:0]  mon;
    logic        sdo_oe_n;
    logic        mon_oe_n;
    logic [3:0]  wr_code;
    logic [3:0]  wr_zero;
    logic [15:0] wdata;
  } qd_state_t;

endpackage

// >>> qd_regs.sv
// qd_regs: serial register block of a quad 16-bit converter
// assumes the serial pins are already synchronous to mclk
`timescale 1ns/1ps
`default_nettype none

module qd_regs
  import qd_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // serial port
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo_o,
  output logic             sdo_oe_n,
  // converter control
  input  wire logic        ldac_n,
  input  wire logic        range_bipolar,
  output logic      [3:0]  gain_x4,
  output logic      [63:0] core_code,
  output logic      [35:0] zero_cal,
  // analogue monitor switch
  output logic      [4:0]  mon_sel,
  output logic             mon_oe_n
);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  qd_state_t st_q;
  qd_state_t st_d;

  logic [15:0] ch_in   [NUM_CH];
  logic [15:0] ch_latch[NUM_CH];

  // frame decode
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        exec;
  logic        is_rd;
  logic [3:0]  addr;
  logic [15:0] frame_data;
  logic [1:0]  ch_idx;
  logic [15:0] cmd_word;
  logic [15:0] mon_word;
  logic [15:0] rd_word;

  assign sclk_rise  = sclk && !st_q.sclk_p && !cs_n;
  assign sclk_fall  = !sclk && st_q.sclk_p && !cs_n;
  assign cs_rise    = cs_n && !st_q.cs_p;
  // short or long frames are dropped whole, nothing is half-written
  assign exec       = cs_rise && (st_q.cnt == 5'(FRAME_BITS));
  assign is_rd      = st_q.in_sh[RW_BIT];
  assign addr       = st_q.in_sh[ADDR_HI:ADDR_LO];
  assign frame_data = st_q.in_sh[DATA_W-1:0];
  assign ch_idx     = addr[1:0];

  // readback images of the control registers
  always_comb begin
    cmd_word                      = '0;
    cmd_word[RB_SEL_BIT]          = st_q.rb_sel;
    cmd_word[SDO_DIS_BIT]         = st_q.serial_out_disable;
    cmd_word[NOP_BIT]             = 1'b0;
    cmd_word[GAIN_HI:GAIN_LO]     = st_q.gain;
    cmd_word[RSVD_HI:0]           = '0;
    mon_word                      = '0;
    mon_word[MON_HI:MON_LO]       = st_q.mon;
  end

  // read multiplexer, unmapped addresses read as zero
  always_comb begin
    rd_word = '0;
    if (addr == ADDR_CMD) begin
      rd_word = cmd_word;
    end else if (addr == ADDR_MON) begin
      rd_word = mon_word;
    end else if (addr[3:2] == ADDR_CODE0[3:2]) begin
      rd_word = st_q.rb_sel ? ch_latch[ch_idx] : ch_in[ch_idx];
    end else if (addr[3:2] == ADDR_ZERO0[3:2]) begin
      rd_word = {{(DATA_W-ZERO_W){1'b0}}, zero_cal[ch_idx*ZERO_W +: ZERO_W]};
    end
  end

  always_comb begin
    st_d         = st_q;
    st_d.sclk_p  = sclk;
    st_d.cs_p    = cs_n;
    st_d.wr_code = '0;
    st_d.wr_zero = '0;

    // shift in on rising edges, count saturates so overlong frames stay invalid
    if (sclk_rise) begin
      st_d.in_sh = {st_q.in_sh[FRAME_BITS-2:0], sdi};
      if (st_q.cnt != 5'h1F) begin
        st_d.cnt = st_q.cnt + 5'd1;
      end
    end
    // shift out on falling edges so the host samples on the next rising edge
    if (sclk_fall) begin
      st_d.out_sh = {st_q.out_sh[FRAME_BITS-2:0], 1'b0};
    end
    if (cs_rise) begin
      st_d.cnt = '0;
    end

    if (exec && is_rd) begin
      // the answer goes out during the next frame
      st_d.out_sh = {st_q.in_sh[FRAME_BITS-1:DATA_W], rd_word};
    end else if (exec) begin
      if (addr == ADDR_CMD) begin
        // no-operation and reserved bits are simply not stored
        st_d.rb_sel = frame_data[RB_SEL_BIT];
        st_d.serial_out_disable   = frame_data[SDO_DIS_BIT];
        st_d.gain   = frame_data[GAIN_HI:GAIN_LO];
      end else if (addr == ADDR_MON) begin
        // more than one bit set is the host's fault; stored as written
        st_d.mon = frame_data[MON_HI:MON_LO];
      end else if (addr[3:2] == ADDR_CODE0[3:2]) begin
        st_d.wr_code[ch_idx] = 1'b1;
      end else if (addr[3:2] == ADDR_ZERO0[3:2]) begin
        st_d.wr_zero[ch_idx] = 1'b1;
      end
      st_d.wdata = frame_data;
    end

    // one cycle behind cs_n; the pin floats outside frames or when disabled
    st_d.sdo_oe_n = st_d.serial_out_disable || cs_n;
    st_d.mon_oe_n = (st_d.mon == MON_RST);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.sclk_p   <= 1'b0;
      st_q.cs_p     <= 1'b1;
      st_q.gain     <= GAIN_RST;
      st_q.mon      <= MON_RST;
      st_q.sdo_oe_n <= 1'b1;
      st_q.mon_oe_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // four identical channels
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      qd_chan u_chan (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .wr_code       (st_q.wr_code[gi]),
        .wr_zero       (st_q.wr_zero[gi]),
        .wdata         (st_q.wdata),
        .ldac_n        (ldac_n),
        .range_bipolar (range_bipolar),
        .in_code       (ch_in[gi]),
        .latch_code    (ch_latch[gi]),
        .core_code     (core_code[gi*DATA_W +: DATA_W]),
        .zero_cal      (zero_cal[gi*ZERO_W +: ZERO_W])
      );
    end
  endgenerate

  assign sdo_o    = st_q.out_sh[FRAME_BITS-1];
  assign sdo_oe_n = st_q.sdo_oe_n;
  assign gain_x4  = st_q.gain;
  assign mon_sel  = st_q.mon;
  assign mon_oe_n = st_q.mon_oe_n;

  // a command write made the disable bit one: pin released from then on
  AST_SDO_DISABLED: assert property (
    (st_q.serial_out_disable && !(exec && !is_rd && addr == ADDR_CMD)) |=> sdo_oe_n)
    else $error("serial output driven while disabled");

  AST_NOP_READS_ZERO: assert property (
    (exec && is_rd && addr == ADDR_CMD) |=> !st_q.out_sh[NOP_BIT])
    else $error("no-operation bit read back as one");

  AST_GAIN_WRITE: assert property (
    (exec && !is_rd && addr == ADDR_CMD)
      |=> gain_x4 == $past(frame_data[GAIN_HI:GAIN_LO]))
    else $error("gain bits not taken from command write");

  AST_CMD_RSVD_ZERO: assert property (
    (exec && is_rd && addr == ADDR_CMD) |=> st_q.out_sh[RSVD_HI:0] == 2'b00)
    else $error("reserved command bits read back non-zero");

  AST_MON_WRITE: assert property (
    (exec && !is_rd && addr == ADDR_MON)
      |=> mon_sel == $past(frame_data[MON_HI:MON_LO]))
    else $error("monitor select not taken from write");

  AST_MON_HIZ: assert property (
    ##1 (mon_oe_n == (mon_sel == MON_RST)))
    else $error("monitor pin state disagrees with selection");

  AST_RESET_VALUES: assert property (@(posedge mclk) disable iff (1'b0)
    !rst_n |=> (mon_sel == MON_RST) && (gain_x4 == GAIN_RST) && sdo_oe_n)
    else $error("control registers not at reset values");

  AST_MON_RSVD_ZERO: assert property (
    (exec && is_rd && addr == ADDR_MON) |=> st_q.out_sh[MON_LO-1:0] == 11'h000)
    else $error("reserved monitor bits read back non-zero");

  AST_READBACK_SRC: assert property (
    (exec && is_rd && addr[3:2] == ADDR_CODE0[3:2])
      |=> st_q.out_sh[DATA_W-1:0] == $past(st_q.rb_sel ? ch_latch[ch_idx] : ch_in[ch_idx]))
    else $error("channel readback from wrong source");

  AST_FRAME_LEN: assert property (
    (cs_rise && st_q.cnt != 5'(FRAME_BITS)) |=> (st_q.wr_code == 4'h0) && (st_q.wr_zero == 4'h0))
    else $error("short or long frame caused a write");

  // the pin follows the frame select one cycle late while enabled
  AST_SDO_IDLE_HIZ: assert property (
    cs_n |=> sdo_oe_n)
    else $error("serial output driven outside a frame");

  AST_SDO_ENABLED: assert property (
    (!cs_n && !st_q.serial_out_disable) |=> !sdo_oe_n)
    else $error("serial output not driven inside an enabled frame");

  AST_SDO_DIS_WRITE: assert property (
    (exec && !is_rd && addr == ADDR_CMD)
      |=> st_q.serial_out_disable == $past(frame_data[SDO_DIS_BIT]))
    else $error("serial-out disable bit not taken from command write");

  AST_CMD_RD_IMAGE: assert property (
    (exec && is_rd && addr == ADDR_CMD)
      |=> st_q.out_sh[GAIN_HI:GAIN_LO] == gain_x4)
    else $error("gain bits read back wrong");

  AST_GAIN_HOLD: assert property (
    !(exec && !is_rd && addr == ADDR_CMD) |=> $stable(gain_x4))
    else $error("gain bits changed without a command write");

  AST_MON_HOLD: assert property (
    !(exec && !is_rd && addr == ADDR_MON) |=> $stable(mon_sel))
    else $error("monitor select changed without a write");

  AST_MON_RD_IMAGE: assert property (
    (exec && is_rd && addr == ADDR_MON)
      |=> st_q.out_sh[MON_HI:MON_LO] == mon_sel)
    else $error("monitor select read back wrong");

  AST_MON_DRIVEN: assert property (
    (mon_sel != MON_RST) |-> !mon_oe_n)
    else $error("monitor pin floating with a source selected");

  // controls and channel storage come out of reset together
  AST_RESET_CHAN: assert property (@(posedge mclk) disable iff (1'b0)
    !rst_n |=> (zero_cal == 36'h0_0000_0000) && (ch_in[0] == CODE_RST)
      && (ch_in[1] == CODE_RST) && (ch_in[2] == CODE_RST)
      && (ch_in[3] == CODE_RST))
    else $error("channel registers not at reset values");

  AST_CODE_STROBE: assert property (
    (exec && !is_rd && addr[3:2] == ADDR_CODE0[3:2])
      |=> st_q.wr_code == 4'(1 << $past(ch_idx)))
    else $error("channel code write strobe missing or misrouted");

  AST_CODE_LANDS: assert property (
    (st_q.wr_code != 4'h0) |=> ch_in[$past(ch_idx, 2)] == $past(st_q.wdata))
    else $error("channel code not stored as written");

  AST_CODE_HOLD: assert property (
    (st_q.wr_code == 4'h0) |=> $stable(ch_in[0]) && $stable(ch_in[1])
      && $stable(ch_in[2]) && $stable(ch_in[3]))
    else $error("channel code changed without a write");

  AST_ZERO_STROBE: assert property (
    (exec && !is_rd && addr[3:2] == ADDR_ZERO0[3:2])
      |=> st_q.wr_zero == 4'(1 << $past(ch_idx)))
    else $error("zero trim write strobe missing or misrouted");

  AST_ZERO_LANDS: assert property (
    (st_q.wr_zero != 4'h0)
      |=> zero_cal[$past(ch_idx, 2)*ZERO_W +: ZERO_W] == $past(st_q.wdata[ZERO_W-1:0]))
    else $error("zero trim not stored as written");

  AST_ZERO_RD_IMAGE: assert property (
    (exec && is_rd && addr[3:2] == ADDR_ZERO0[3:2])
      |=> st_q.out_sh[DATA_W-1:ZERO_W] == 7'h00)
    else $error("zero trim upper bits read back non-zero");

  AST_RB_SEL_WRITE: assert property (
    (exec && !is_rd && addr == ADDR_CMD)
      |=> st_q.rb_sel == $past(frame_data[RB_SEL_BIT]))
    else $error("readback source bit not taken from command write");

  // the read frame's own header comes back ahead of the data word
  AST_RD_ECHO: assert property (
    (exec && is_rd)
      |=> st_q.out_sh[FRAME_BITS-1:DATA_W] == $past(st_q.in_sh[FRAME_BITS-1:DATA_W]))
    else $error("read header not echoed");

  AST_RD_UNMAPPED: assert property (
    (exec && is_rd && (addr[3:2] == 2'h3 || addr[3:1] == 3'h1))
      |=> st_q.out_sh[DATA_W-1:0] == 16'h0000)
    else $error("unmapped address read back non-zero");

  AST_RD_NO_WRITE: assert property (
    (exec && is_rd) |=> (st_q.wr_code == 4'h0) && (st_q.wr_zero == 4'h0)
      && $stable(gain_x4) && $stable(mon_sel))
    else $error("read frame changed a register");

  AST_CNT_CLEAR: assert property (
    cs_rise |=> st_q.cnt == 5'h00)
    else $error("bit count not cleared at frame end");

  // each sclk fall moves the next answer bit onto the pin
  AST_SDO_SHIFT: assert property (
    sclk_fall |=> sdo_o == $past(st_q.out_sh[FRAME_BITS-2]))
    else $error("serial output did not advance on falling clock");

  AST_SDI_SHIFT: assert property (
    sclk_rise |=> st_q.in_sh[0] == $past(sdi))
    else $error("serial input bit not taken on rising clock");

endmodule

`default_nettype wire

// >>> test_quad_dac_config_registers.sv
// test_quad_dac_config_registers: register block against a queue-free model
// assumes qd_host drives the serial port and the bench drives load and range
`timescale 1ns/1ps
`default_nettype none

module test_quad_dac_config_registers;
  import qd_pkg::*;
  logic        mclk   = 1'b0;
  logic        rst_n  = 1'b0;
  logic        ldac_n = 1'b1;
  logic        bip    = 1'b0;
  wire         sclk, cs_n, sdi, sdo_o, sdo_oe_n, mon_oe_n;
  wire  [3:0]  gain_x4;
  wire  [63:0] core_code;
  wire  [35:0] zero_cal;
  wire  [4:0]  mon_sel;
  int          err_total  = 0;
  int          n_compared = 0;
  logic [15:0] m_code[4], m_lat[4], d;
  logic [8:0]  m_zero[4];
  logic [4:0]  m_mon;
  logic [3:0]  m_gain;
  logic        m_rb, m_dis;
  logic [23:0] r;
  logic [15:0] bc[4] = '{16'h7fff, 16'h0000, 16'hffff, 16'h8000};

  always #20 mclk = ~mclk;

  qd_regs u_qd_regs (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .ldac_n(ldac_n), .range_bipolar(bip),
    .gain_x4(gain_x4), .core_code(core_code), .zero_cal(zero_cal), .mon_sel(mon_sel),
    .mon_oe_n(mon_oe_n));
  qd_host u_qd_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o),
    .sdo_oe_n(sdo_oe_n));

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic give_verdict;
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic m_rst;
    {m_rb, m_dis, m_gain, m_mon} = {2'b00, GAIN_RST, MON_RST};
    for (int c = 0; c < 4; c++) {m_code[c], m_lat[c], m_zero[c]} = '0;
  endtask

  function automatic logic [15:0] rv(input logic [3:0] a);
    rv = 16'h0000;
    if (a == ADDR_CMD) rv = {m_rb, 7'h00, m_dis, 1'b0, m_gain, 2'h0};
    if (a == ADDR_MON) rv = {m_mon, 11'h000};
    if (a[3:2] == 2'b01) rv = m_rb ? m_lat[a[1:0]] : m_code[a[1:0]];
    if (a[3:2] == 2'b10) rv = {7'h00, m_zero[a[1:0]]};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    u_qd_host.xfer({4'h0, a, v}, 24, r);
    if (a == ADDR_CMD) {m_rb, m_dis, m_gain} = {v[15], v[7], v[5:2]};
    if (a == ADDR_MON) m_mon = v[15:11];
    if (a[3:2] == 2'b01) m_code[a[1:0]] = v;
    if (a[3:2] == 2'b10) m_zero[a[1:0]] = v[8:0];
  endtask

  // answer comes out during the following frame, sent to an unmapped place
  task automatic rd(input logic [3:0] a);
    u_qd_host.xfer({4'h8, a, 16'h0000}, 24, r);
    u_qd_host.xfer({4'h0, 4'hf, 16'h0000}, 24, r);
    if (m_dis) chk(u_qd_host.drove, 1'b0);
    else chk(r, {4'h8, a, rv(a)});
  endtask

  task automatic chk_out;
    chk(gain_x4, m_gain);
    chk(mon_sel, m_mon);
    chk(mon_oe_n, m_mon == 5'h00);
    for (int c = 0; c < 4; c++) begin
      chk(core_code[16*c +: 16], m_lat[c] ^ {bip, 15'h0000});
      chk(zero_cal[9*c +: 9], m_zero[c]);
    end
  endtask

  // level load: hold low a few cycles so every latch and core copy lands
  task automatic load;
    @(posedge mclk) ldac_n <= 1'b0;
    repeat (3) @(posedge mclk);
    ldac_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int c = 0; c < 4; c++) m_lat[c] = m_code[c];
  endtask

  initial begin
    void'($urandom(32'hcec8_8dc0));
    m_rst;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(sdo_oe_n, 1'b1);
    chk_out;
    for (int a = 0; a < 16; a++) rd(a[3:0]);
    repeat (4) begin
      d = 16'($urandom) & 16'hff7f;
      wr(ADDR_CMD, d);
      rd(ADDR_CMD);
      chk_out;
    end
    wr(ADDR_CMD, 16'h003c);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_MON, {5'(1 << i), 11'($urandom)});
      // a cut frame that would clear the selection must be dropped whole
      u_qd_host.xfer({4'h0, ADDR_MON, 16'h0000}, 23 - i, r);
      chk_out;
      rd(ADDR_MON);
    end
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CODE0 + 4'(c), 16'($urandom));
      wr(ADDR_ZERO0 + 4'(c), 16'($urandom));
      rd(ADDR_CODE0 + 4'(c));
      rd(ADDR_ZERO0 + 4'(c));
    end
    chk_out;
    load;
    chk_out;
    wr(ADDR_CMD, 16'h803c);
    wr(ADDR_CODE0, 16'h1234);
    chk_out;
    for (int c = 0; c < 4; c++) rd(ADDR_CODE0 + 4'(c));
    for (int b = 0; b < 2; b++) begin
      bip <= b[0];
      for (int k = 0; k < 4; k++) begin
        wr(ADDR_CODE0, bc[k]);
        load;
        chk_out;
      end
    end
    wr(ADDR_CMD, 16'h00bc);
    rd(ADDR_MON);
    wr(ADDR_CMD, 16'h003c);
    rd(ADDR_CMD);
    @(posedge mclk) rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    m_rst;
    repeat (3) @(posedge mclk);
    chk_out;
    give_verdict;
  end

  initial begin
    #(40 * 40000);
    err_total++;
    give_verdict;
  end
endmodule

`default_nettype wire
